// [core/evcfg_pkg.sv]
/*
 * Constants for the event input control block: register offset, field
 * positions, reset value and sampling timing.
 * Assumes a 50 MHz core clock.
 */
package evcfg_pkg;
   localparam logic [7:0] EVCFG_CTRL_OFFSET    = 8'h15;
   localparam logic [7:0] EVCFG_CTRL_RESET     = 8'h00;
   localparam logic [7:0] EVCFG_CTRL_WR_MASK   = 8'hF1;
   localparam int         EVCFG_DELAY_EN_BIT   = 7;
   localparam int         EVCFG_POLARITY_BIT   = 6;
   localparam int         EVCFG_FILTER_HI_BIT  = 5;
   localparam int         EVCFG_FILTER_LO_BIT  = 4;
   localparam int         EVCFG_SYNC_BIT       = 0;
   localparam logic [1:0] EVCFG_FILT_NONE      = 2'h0;
   localparam logic [1:0] EVCFG_FILT_256HZ     = 2'h1;
   localparam logic [1:0] EVCFG_FILT_64HZ      = 2'h2;
   localparam logic [1:0] EVCFG_FILT_8HZ       = 2'h3;
   localparam int         EVCFG_CLK_MHZ        = 50;
   localparam int         EVCFG_SP_256HZ_US    = 3900;
   localparam int         EVCFG_SP_64HZ_US     = 15600;
   localparam int         EVCFG_SP_8HZ_US      = 125000;
   localparam int         EVCFG_SP_256HZ_CYC   = EVCFG_SP_256HZ_US * EVCFG_CLK_MHZ;
   localparam int         EVCFG_SP_64HZ_CYC    = EVCFG_SP_64HZ_US * EVCFG_CLK_MHZ;
   localparam int         EVCFG_SP_8HZ_CYC     = EVCFG_SP_8HZ_US * EVCFG_CLK_MHZ;
   localparam int         EVCFG_CNT_W          = 23;
endpackage : evcfg_pkg

// [core/evcfg_event_input.sv]
/*
 * Event input control register with polarity, optional sampling filter
 * and clock output switch-off delay enable.
 * Assumes all inputs are synchronous to core_clk and the register write
 * strobe comes from the serial bus slave outside this block.
 */
// Summary of operation
// - STOP: immediate off, or delayed when enabled
// - Polarity zero: falling edge or low level
// - Polarity one: rising edge or high level
// - Nonzero filter field samples pin periodically
// - Filter field zero: plain edge detection
// - Setting 01 samples every 3.9 ms
// - Setting 11 samples every 125 ms
// - Setting 10 samples every 15.6 ms
// - Unused register bits read as zero
`timescale 1ns/1ns
`default_nettype none
module evcfg_event_input
   import evcfg_pkg::*;
#(
   parameter int SP_256HZ_CYC = evcfg_pkg::EVCFG_SP_256HZ_CYC,
   parameter int SP_64HZ_CYC  = evcfg_pkg::EVCFG_SP_64HZ_CYC,
   parameter int SP_8HZ_CYC   = evcfg_pkg::EVCFG_SP_8HZ_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       external_event_input_pin,
   input  wire logic       i2c_stop,
   input  wire logic       clock_out_delay_select,
   output logic            clock_output_pin_off_pulse,
   output logic            clock_output_pin_delay_start,
   output logic            clock_output_pin_delay_sel,
   output logic            event_sync_bit,
   output logic            event_pulse,
   output logic            event_level
);
   import evcfg_pkg::*;

   // ********************************************************
   // Register
   // ********************************************************
   logic [7:0]             ctrl_reg;
   logic [1:0]             event_filter_time;
   logic                   event_polarity_select;
   logic                   clock_out_stop_delay_enable;
   logic                   wr_hit;

   assign event_filter_time           = ctrl_reg[EVCFG_FILTER_HI_BIT:EVCFG_FILTER_LO_BIT];
   assign event_polarity_select       = ctrl_reg[EVCFG_POLARITY_BIT];
   assign clock_out_stop_delay_enable = ctrl_reg[EVCFG_DELAY_EN_BIT];
   assign wr_hit                      = reg_wr && (reg_addr == EVCFG_CTRL_OFFSET);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_reg <= EVCFG_CTRL_RESET;
      end else if (wr_hit) begin
         ctrl_reg <= reg_wdata & EVCFG_CTRL_WR_MASK;
      end
   end

   assign reg_rdata      = ctrl_reg;
   assign event_sync_bit = ctrl_reg[EVCFG_SYNC_BIT];

   // ********************************************************
   // Clock output switch-off after STOP
   // ********************************************************
   logic clock_output_pin_off_reg;
   logic delay_start_reg;
   logic delay_sel_reg;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         clock_output_pin_off_reg  <= 1'b0;
         delay_start_reg <= 1'b0;
         delay_sel_reg   <= 1'b0;
      end else begin
         clock_output_pin_off_reg  <= i2c_stop && !clock_out_stop_delay_enable;
         delay_start_reg <= i2c_stop && clock_out_stop_delay_enable;
         if (i2c_stop && clock_out_stop_delay_enable) begin
            delay_sel_reg <= clock_out_delay_select;
         end
      end
   end

   assign clock_output_pin_off_pulse   = clock_output_pin_off_reg;
   assign clock_output_pin_delay_start = delay_start_reg;
   assign clock_output_pin_delay_sel   = delay_sel_reg;

   // ********************************************************
   // Sampling timebase
   // ********************************************************
   function automatic logic [EVCFG_CNT_W-1:0] period_last(input logic [1:0] code);
      case (code)
         EVCFG_FILT_256HZ: period_last = EVCFG_CNT_W'(SP_256HZ_CYC - 1);
         EVCFG_FILT_64HZ:  period_last = EVCFG_CNT_W'(SP_64HZ_CYC - 1);
         EVCFG_FILT_8HZ:   period_last = EVCFG_CNT_W'(SP_8HZ_CYC - 1);
         default:          period_last = '0;
      endcase
   endfunction : period_last

   logic [EVCFG_CNT_W-1:0] samp_cnt_reg;
   logic                   tick;

   assign tick = (event_filter_time != EVCFG_FILT_NONE) && (samp_cnt_reg == '0);

   always_ff @(posedge core_clk) begin
      if (reset || (event_filter_time == EVCFG_FILT_NONE)) begin
         samp_cnt_reg <= '0;
      end else if (samp_cnt_reg == '0) begin
         samp_cnt_reg <= period_last(event_filter_time);
      end else begin
         samp_cnt_reg <= samp_cnt_reg - 1'b1;
      end
   end

   // ********************************************************
   // Event detection
   // ********************************************************
   logic pin_reg;
   logic sample_reg;
   logic pulse_reg;
   logic level_reg;
   logic fall_seen;
   logic rise_seen;
   logic samp_now;

   assign fall_seen = tick ? (sample_reg && !pin_reg) : 1'b0;
   assign rise_seen = tick ? (!sample_reg && pin_reg) : 1'b0;
   assign samp_now  = tick ? pin_reg : sample_reg;

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= external_event_input_pin;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         sample_reg <= 1'b0;
      end else if (tick || (event_filter_time == EVCFG_FILT_NONE)) begin
         sample_reg <= pin_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pulse_reg <= 1'b0;
         level_reg <= 1'b0;
      end else if (event_filter_time == EVCFG_FILT_NONE) begin
         pulse_reg <= event_polarity_select ? (!pin_reg && external_event_input_pin)
                                            : (pin_reg && !external_event_input_pin);
         level_reg <= 1'b0;
      end else begin
         pulse_reg <= event_polarity_select ? rise_seen : fall_seen;
         level_reg <= (samp_now == event_polarity_select);
      end
   end

   assign event_pulse = pulse_reg;
   assign event_level = level_reg;

   // ********************************************************
   // Checks
   // ********************************************************
   logic [EVCFG_CNT_W-1:0] gap_reg;
   logic                   et_chg_reg;

   always_ff @(posedge core_clk) begin
      if (reset || tick) begin
         gap_reg    <= '0;
         et_chg_reg <= reset || wr_hit;
      end else begin
         gap_reg    <= gap_reg + 1'b1;
         et_chg_reg <= et_chg_reg || wr_hit;
      end
   end

   a_reserved_zero: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_reg[3:1] == 3'h0) else $error("reserved bits not zero");
   a_write_takes: assert property (@(posedge core_clk) disable iff (reset)
      wr_hit |=> ctrl_reg == ($past(reg_wdata) & 8'hF1)) else $error("write lost");
   a_fall_edge: assert property (@(posedge core_clk) disable iff (reset)
      (ctrl_reg[5:4] == 2'h0 && !ctrl_reg[6] && pin_reg && !external_event_input_pin)
      |=> event_pulse) else $error("falling edge missed");
   a_rise_edge: assert property (@(posedge core_clk) disable iff (reset)
      (ctrl_reg[5:4] == 2'h0 && ctrl_reg[6] && !pin_reg && external_event_input_pin)
      |=> event_pulse) else $error("rising edge missed");
   a_nofilt_level: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_reg[5:4] == 2'h0 |=> !event_level) else $error("level in edge mode");
   a_filt_on_tick: assert property (@(posedge core_clk) disable iff (reset)
      (ctrl_reg[5:4] != 2'h0 && !tick) |=> !event_pulse) else $error("pulse off tick");
   a_period_256: assert property (@(posedge core_clk) disable iff (reset)
      (tick && !et_chg_reg && ctrl_reg[5:4] == 2'h1)
      |-> gap_reg == EVCFG_CNT_W'(SP_256HZ_CYC - 1)) else $error("bad 256 Hz period");
   a_period_64: assert property (@(posedge core_clk) disable iff (reset)
      (tick && !et_chg_reg && ctrl_reg[5:4] == 2'h2)
      |-> gap_reg == EVCFG_CNT_W'(SP_64HZ_CYC - 1)) else $error("bad 64 Hz period");
   a_period_8: assert property (@(posedge core_clk) disable iff (reset)
      (tick && !et_chg_reg && ctrl_reg[5:4] == 2'h3)
      |-> gap_reg == EVCFG_CNT_W'(SP_8HZ_CYC - 1)) else $error("bad 8 Hz period");
   a_stop_now: assert property (@(posedge core_clk) disable iff (reset)
      (i2c_stop && !ctrl_reg[7]) |=> clock_output_pin_off_pulse && !clock_output_pin_delay_start)
      else $error("immediate switch-off missing");
   a_stop_delay: assert property (@(posedge core_clk) disable iff (reset)
      (i2c_stop && ctrl_reg[7]) |=> !clock_output_pin_off_pulse && clock_output_pin_delay_start
      && clock_output_pin_delay_sel == $past(clock_out_delay_select))
      else $error("delayed switch-off missing");

   c_edge_event: cover property (@(posedge core_clk) disable iff (reset)
      ctrl_reg[5:4] == 2'h0 && event_pulse);
   c_filt_event: cover property (@(posedge core_clk) disable iff (reset)
      ctrl_reg[5:4] != 2'h0 && event_pulse);
   c_level_event: cover property (@(posedge core_clk) disable iff (reset) event_level);
   c_delay_stop: cover property (@(posedge core_clk) disable iff (reset) clock_output_pin_delay_start);
endmodule : evcfg_event_input
`default_nettype wire

// [testbench/evcfg_pin_src.sv]
/*
 * Partner model: external signal source that drives the event input pin.
 * Assumes the bench changes level_req at a falling clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module evcfg_pin_src (
   input  wire logic core_clk,
   input  wire logic level_req,
   output var  logic pin
);
   // Push-pull source, so the pin always shows a firm level.
   always @(negedge core_clk) begin
      pin <= level_req;
   end
endmodule : evcfg_pin_src
`default_nettype wire

// [testbench/event_input_detect_config_tb.sv]
/*
 * Self-checking bench for the event input control block.
 * Assumes a 50 MHz clock and short sampling periods set by parameter.
 */
`timescale 1ns/1ns
`default_nettype none
module event_input_detect_config_tb;
   import evcfg_pkg::*;
   localparam int P1 = 20, P2 = 40, P3 = 80;
   logic       core_clk, reset, reg_wr, i2c_stop, dsel, pin_req, pin;
   logic [7:0] reg_addr, reg_wdata, rdata;
   logic       off_p, dly_p, dly_sel, sync_b, ev_p, ev_l;
   int         fail_count = 0, total_checks = 0, cycles = 0;
   // ****************************************
   // Instances, clock, timeout and helpers
   // ****************************************
   evcfg_event_input #(.SP_256HZ_CYC(P1), .SP_64HZ_CYC(P2), .SP_8HZ_CYC(P3)) u_dut (
      .core_clk(core_clk), .reset(reset), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(rdata), .external_event_input_pin(pin),
      .i2c_stop(i2c_stop), .clock_out_delay_select(dsel), .clock_output_pin_off_pulse(off_p),
      .clock_output_pin_delay_start(dly_p), .clock_output_pin_delay_sel(dly_sel), .event_sync_bit(sync_b),
      .event_pulse(ev_p), .event_level(ev_l));
   evcfg_pin_src u_src (.core_clk(core_clk), .level_req(pin_req), .pin(pin));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic stop;
      @(negedge core_clk);
      i2c_stop = 1'b1;
      @(negedge core_clk);
      i2c_stop = 1'b0;
   endtask : stop
   task automatic pin_to(input logic v, output int c);
      c = 0;
      pin_req <= v;
      repeat (5) begin
         @(negedge core_clk);
         if (ev_p === 1'b1) c++;
      end
   endtask : pin_to
   task automatic wait_lvl(input logic v, output int n, output int c);
      n = 0; c = 0;
      do begin
         @(negedge core_clk);
         n++;
         if (ev_p === 1'b1) c++;
      end while (ev_l !== v && n < 400);
   endtask : wait_lvl
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reg;
      check(rdata, EVCFG_CTRL_RESET);
      check(8'({off_p, dly_p, ev_p, ev_l, sync_b}), 8'h00);
      wr(EVCFG_CTRL_OFFSET, 8'hFF);
      check(rdata, 8'hF1);
      check(8'(sync_b), 8'h01);
      wr(8'h16, 8'h00);
      check(rdata, 8'hF1);
      $display("test register done");
   endtask : t_reg
   task automatic t_stop;
      wr(EVCFG_CTRL_OFFSET, 8'h00);
      stop();
      check(8'({off_p, dly_p}), 8'h02);
      @(negedge core_clk);
      check(8'({off_p, dly_p}), 8'h00);
      wr(EVCFG_CTRL_OFFSET, 8'h80);
      dsel = 1'b1;
      stop();
      check(8'({off_p, dly_p, dly_sel}), 8'h03);
      dsel = 1'b0;
      stop();
      check(8'({off_p, dly_p, dly_sel}), 8'h02);
      $display("test stop done");
   endtask : t_stop
   task automatic t_edge;
      int c;
      wr(EVCFG_CTRL_OFFSET, 8'h00);
      pin_to(1'b0, c);
      check(8'(c), 8'h01);
      check(8'(ev_l), 8'h00);
      pin_to(1'b1, c);
      check(8'(c), 8'h00);
      wr(EVCFG_CTRL_OFFSET, 8'h40);
      pin_to(1'b0, c);
      check(8'(c), 8'h00);
      pin_to(1'b1, c);
      check(8'(c), 8'h01);
      $display("test edge done");
   endtask : t_edge
   task automatic t_filt(input logic [1:0] code, input logic pol, input int p);
      int n, c;
      wr(EVCFG_CTRL_OFFSET, {1'b0, pol, code, 4'h0});
      repeat (2) @(negedge core_clk);
      pin_req <= pol;
      wait_lvl(1'b1, n, c);
      pin_req <= !pol;
      wait_lvl(1'b0, n, c);
      pin_req <= pol;
      wait_lvl(1'b1, n, c);
      check(8'(n >= p - 3 && n <= p + 3), 8'h01);
      check(8'(c), 8'h01);
      $display("test filter %0d polarity %0d done", code, pol);
   endtask : t_filt
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      reset = 1'b1; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      i2c_stop = 1'b0; dsel = 1'b0; pin_req = 1'b1;
      repeat (16) @(negedge core_clk);
      reset = 1'b0;
      t_reg();
      t_stop();
      t_edge();
      t_filt(EVCFG_FILT_256HZ, 1'b0, P1);
      t_filt(EVCFG_FILT_64HZ, 1'b0, P2);
      t_filt(EVCFG_FILT_8HZ, 1'b0, P3);
      t_filt(EVCFG_FILT_256HZ, 1'b1, P1);
      conclude();
   end
endmodule : event_input_detect_config_tb
`default_nettype wire
